// ===== hw/uart_autobaud_map.vh
// Constants for the autobaud asynchronous serial block
`ifndef UART_AUTOBAUD_MAP_VH
`define UART_AUTOBAUD_MAP_VH
// ----------------------------------------
// Clock and prescale
// ----------------------------------------
`define CLK_HZ          40000000
`define PRE_W           9
`define PRE_512         9'h1FF
`define PRE_128         9'h07F
`define PRE_32          9'h01F
`define MEAS_DIV_W      3
`define MEAS_DIV_LAST   3'h7
// ----------------------------------------
// Framing and sampling
// ----------------------------------------
`define EDGE_LAST       3'h5
`define OVS16_LAST      6'h0F
`define OVS64_LAST      6'h3F
`define OVS_MID16       6'h07
`define OVS_MID64       6'h1F
`define BITS_8          4'h8
`define BITS_9          4'h9
`define DIV_RESET       16'h0000
`define DIV_ONE         16'h0001
`define DIV_FOUR        16'h0004
`endif

// ===== hw/async_uart_autobaud.v
// Asynchronous serial transceiver with rate divider and autobaud measurement
// Operation
// - Autobaud only when async, with or without wake
// - Measure starts on start bit with enable
// - Enable clears divider, then awaits start
// - Count from first rising edge after start
// - Fifth rise stores count, clears enable
// - Counter clocked at one eighth rate
// - Divider pair counts as 16 bits
// - Prescale 512, 128 or 32 by bits
// - Transceiver held idle while measuring
// - Fifth rise raises receive complete flag
// - With wake enable, measure byte after break
// - Clocked-mode bit clear selects async
// - Start, eight or nine data, stop
// - Data shifted least significant bit first
// - Transmitter and receiver run independently
// - Sample tick at 16x or 64x rate
// - No hardware parity; ninth bit raw
// - Async stays available in low power
// - Divider 1040 at 40 MHz gives 9606 baud in wide high-speed mode
`include "uart_autobaud_map.vh"
module async_uart_autobaud (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        syncModeSelect,
   input  wire        wakeOnBreakEnable,
   input  wire        highSpeedSelect,
   input  wire        wideDividerSelect,
   input  wire        autobaudSet,
   input  wire        dividerWrite,
   input  wire [15:0] dividerWriteValue,
   input  wire        nineBitMode,
   input  wire        txValid,
   input  wire [8:0]  txData,
   output wire        txReady,
   input  wire        rxIn,
   output reg         txOut,
   output wire        rxValid,
   output wire [8:0]  rxData,
   input  wire        rxReady,
   output reg         autobaudEnable,
   output wire        autobaudMeasure,
   output reg  [7:0]  rateDividerLow,
   output reg  [7:0]  rateDividerHigh,
   output reg         receiveCompleteFlag,
   input  wire        receiveBufferRead,
   output reg         breakSeen
);
   // ----------------------------------------
   // Reset release and input synchroniser
   // ----------------------------------------
   reg        rstMeta;
   reg        rstSync;
   reg        rxMeta;
   reg        rxSync;
   reg        rxPrev;
   reg        rxDone;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end
   wire       rst_sync_n = rstSync;
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
         rxPrev <= 1'b1;
      end else begin
         rxMeta <= rxIn;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
      end
   end
   wire       rxRise    = rxSync & ~rxPrev;
   wire       rxFall    = ~rxSync & rxPrev;
   wire       asyncMode = ~syncModeSelect;
   // ----------------------------------------
   // Measurement prescale
   // ----------------------------------------
   // One oscillator clock serves all low-power modes; rates need no retune
   reg  [`PRE_W-1:0]      preCnt;
   reg  [`MEAS_DIV_W-1:0] measDiv;
   reg  [`PRE_W-1:0]      preLast;
   wire                   preTick;
   wire                   measTick;
   always @* begin
      case ({wideDividerSelect, highSpeedSelect})
         2'b00:   preLast = `PRE_512;
         2'b11:   preLast = `PRE_32;
         default: preLast = `PRE_128;
      endcase
   end
   assign preTick  = (preCnt >= preLast);
   assign measTick = preTick && (measDiv == `MEAS_DIV_LAST);
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         preCnt  <= {`PRE_W{1'b0}};
         measDiv <= {`MEAS_DIV_W{1'b0}};
      end else if (preTick) begin
         preCnt  <= {`PRE_W{1'b0}};
         measDiv <= measDiv + 3'h1;
      end else begin
         preCnt  <= preCnt + 9'h001;
      end
   end
   // ----------------------------------------
   // Autobaud state machine
   // ----------------------------------------
   localparam [4:0] AB_IDLE  = 5'b00001;
   localparam [4:0] AB_BREAK = 5'b00010;
   localparam [4:0] AB_START = 5'b00100;
   localparam [4:0] AB_RISE1 = 5'b01000;
   localparam [4:0] AB_COUNT = 5'b10000;
   reg  [4:0]  abState;
   reg  [2:0]  riseCnt;
   wire [15:0] divider;
   wire        abAllowed;
   assign divider   = {rateDividerHigh, rateDividerLow};
   assign abAllowed = asyncMode;
   assign autobaudMeasure = (abState == AB_RISE1) || (abState == AB_COUNT);
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         abState             <= AB_IDLE;
         riseCnt             <= 3'h0;
         autobaudEnable      <= 1'b0;
         rateDividerLow      <= 8'h00;
         rateDividerHigh     <= 8'h00;
         receiveCompleteFlag <= 1'b0;
         breakSeen           <= 1'b0;
      end else begin
         if (receiveBufferRead)
            receiveCompleteFlag <= 1'b0;
         if (rxDone)
            receiveCompleteFlag <= 1'b1;
         case (abState)
            AB_IDLE: begin
               if (dividerWrite) begin
                  rateDividerLow  <= dividerWriteValue[7:0];
                  rateDividerHigh <= dividerWriteValue[15:8];
               end
               if (autobaudSet && abAllowed) begin
                  autobaudEnable  <= 1'b1;
                  rateDividerLow  <= 8'h00;
                  rateDividerHigh <= 8'h00;
                  breakSeen       <= 1'b0;
                  abState <= wakeOnBreakEnable ? AB_BREAK : AB_START;
               end
            end
            AB_BREAK: begin
               // Break is a long low; its rising end arms the next start bit
               if (rxRise) begin
                  breakSeen <= 1'b1;
                  abState   <= AB_START;
               end
            end
            AB_START: begin
               riseCnt <= 3'h0;
               if (rxFall)
                  abState <= AB_RISE1;
            end
            AB_RISE1: begin
               if (rxRise) begin
                  riseCnt <= 3'h1;
                  abState <= AB_COUNT;
               end
            end
            AB_COUNT: begin
               if (measTick)
                  {rateDividerHigh, rateDividerLow} <= divider + `DIV_ONE;
               if (rxRise) begin
                  riseCnt <= riseCnt + 3'h1;
                  if (riseCnt + 3'h1 == `EDGE_LAST) begin
                     autobaudEnable      <= 1'b0;
                     receiveCompleteFlag <= 1'b1;
                     abState             <= AB_IDLE;
                  end
               end
            end
            default: abState <= AB_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // Baud tick generator
   // ----------------------------------------
   // Wide high-speed mode steps four per clock, so 1040 at 40 MHz gives 9606 baud;
   // a reload below the step ticks every clock, which caps that mode's top rate
   reg  [15:0] baudCnt;
   reg         sampleTick;
   wire        useX64   = ~highSpeedSelect & ~wideDividerSelect;
   wire [5:0]  ovsLast  = useX64 ? `OVS64_LAST : `OVS16_LAST;
   wire [5:0]  ovsMid   = useX64 ? `OVS_MID64 : `OVS_MID16;
   wire        trxIdle  = autobaudEnable | ~asyncMode;
   wire [15:0] baudLoad = wideDividerSelect ? divider : {8'h00, rateDividerLow};
   wire [15:0] baudStep = (highSpeedSelect & wideDividerSelect) ? `DIV_FOUR : `DIV_ONE;
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         baudCnt    <= `DIV_RESET;
         sampleTick <= 1'b0;
      end else if (trxIdle) begin
         baudCnt    <= baudLoad;
         sampleTick <= 1'b0;
      end else if (baudCnt < baudStep) begin
         baudCnt    <= (baudLoad < baudStep) ? `DIV_RESET
                       : baudCnt + baudLoad + `DIV_ONE - baudStep;
         sampleTick <= 1'b1;
      end else begin
         baudCnt    <= baudCnt - baudStep;
         sampleTick <= 1'b0;
      end
   end
   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   localparam [2:0] TX_IDLE = 3'b001;
   localparam [2:0] TX_SEND = 3'b010;
   localparam [2:0] TX_STOP = 3'b100;
   reg [2:0] txState;
   reg [5:0] txOvs;
   reg [3:0] txBit;
   reg [8:0] txShift;
   wire [3:0] nBits;
   assign nBits   = nineBitMode ? `BITS_9 : `BITS_8;
   assign txReady = (txState == TX_IDLE) && !trxIdle;
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         txState <= TX_IDLE;
         txOvs   <= 6'h00;
         txBit   <= 4'h0;
         txShift <= 9'h000;
         txOut   <= 1'b1;
      end else if (trxIdle) begin
         txState <= TX_IDLE;
         txOut   <= 1'b1;
      end else begin
         case (txState)
            TX_IDLE: begin
               txOut <= 1'b1;
               if (txValid) begin
                  txShift <= txData;
                  txOvs   <= 6'h00;
                  txBit   <= 4'h0;
                  txOut   <= 1'b0;
                  txState <= TX_SEND;
               end
            end
            TX_SEND: if (sampleTick) begin
               if (txOvs == ovsLast) begin
                  txOvs <= 6'h00;
                  if (txBit == nBits) begin
                     txOut   <= 1'b1;
                     txState <= TX_STOP;
                  end else begin
                     txOut   <= txShift[0];
                     txShift <= {1'b0, txShift[8:1]};
                     txBit   <= txBit + 4'h1;
                  end
               end else begin
                  txOvs <= txOvs + 6'h01;
               end
            end
            TX_STOP: if (sampleTick) begin
               if (txOvs == ovsLast)
                  txState <= TX_IDLE;
               else
                  txOvs <= txOvs + 6'h01;
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // Receiver and two-entry buffer
   // ----------------------------------------
   localparam [2:0] RX_IDLE = 3'b001;
   localparam [2:0] RX_DATA = 3'b010;
   localparam [2:0] RX_STOP = 3'b100;
   reg  [2:0] rxState;
   reg  [5:0] rxOvs;
   reg  [3:0] rxBit;
   reg  [8:0] rxShift;
   reg  [8:0] bufMem [0:1];
   reg        wrPtr;
   reg        rdPtr;
   reg  [1:0] bufCount;
   wire       bufPush;
   wire       bufPop;
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rxState <= RX_IDLE;
         rxOvs   <= 6'h00;
         rxBit   <= 4'h0;
         rxShift <= 9'h000;
         rxDone  <= 1'b0;
      end else begin
         rxDone <= 1'b0;
         if (trxIdle) begin
            rxState <= RX_IDLE;
         end else begin
            case (rxState)
               RX_IDLE: if (rxFall) begin
                  rxOvs   <= 6'h00;
                  rxBit   <= 4'h0;
                  rxShift <= 9'h000;
                  rxState <= RX_DATA;
               end
               RX_DATA: if (sampleTick) begin
                  if (rxOvs == ovsMid && rxBit == 4'h0 && rxSync) begin
                     rxState <= RX_IDLE;
                  end else if (rxOvs == ovsLast) begin
                     rxOvs <= 6'h00;
                     if (rxBit == nBits)
                        rxState <= RX_STOP;
                     rxBit <= rxBit + 4'h1;
                  end else begin
                     rxOvs <= rxOvs + 6'h01;
                     if (rxOvs == ovsMid && rxBit != 4'h0) begin
                        if (nineBitMode)
                           rxShift <= {rxSync, rxShift[8:1]};
                        else
                           rxShift <= {1'b0, rxSync, rxShift[7:1]};
                     end
                  end
               end
               RX_STOP: if (sampleTick) begin
                  if (rxOvs == ovsMid) begin
                     rxDone  <= bufCount != 2'h2;
                     rxState <= RX_IDLE;
                  end else begin
                     rxOvs <= rxOvs + 6'h01;
                  end
               end
               default: rxState <= RX_IDLE;
            endcase
         end
      end
   end
   // Full buffer drops the new word; receiver keeps resyncing on start bits
   assign bufPush = rxDone;
   assign bufPop  = rxValid && rxReady;
   assign rxValid = bufCount != 2'h0;
   assign rxData  = bufMem[rdPtr];
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bufMem[0] <= 9'h000;
         bufMem[1] <= 9'h000;
         wrPtr     <= 1'b0;
         rdPtr     <= 1'b0;
         bufCount  <= 2'h0;
      end else begin
         if (bufPush) begin
            bufMem[wrPtr] <= rxShift;
            wrPtr         <= ~wrPtr;
         end
         if (bufPop)
            rdPtr <= ~rdPtr;
         bufCount <= bufCount + {1'b0, bufPush} - {1'b0, bufPop};
      end
   end
endmodule

// ===== tb/async_uart_autobaud_sva.sv
// Concurrent checks on the ports of the autobaud serial block
module async_uart_autobaud_sva (
   input wire        clk,
   input wire        rst_n,
   input wire        syncModeSelect,
   input wire        autobaudSet,
   input wire        dividerWrite,
   input wire [15:0] dividerWriteValue,
   input wire        txValid,
   input wire        txReady,
   input wire        txOut,
   input wire        autobaudEnable,
   input wire        autobaudMeasure,
   input wire [7:0]  rateDividerLow,
   input wire [7:0]  rateDividerHigh,
   input wire        receiveCompleteFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_abStart;
      autobaudSet && !syncModeSelect && !autobaudEnable
         |=> autobaudEnable && {rateDividerHigh, rateDividerLow} == 16'h0000;
   endproperty
   a_abStart: assert property (p_abStart) else $error("autobaud start not taken");
   property p_syncRefuse;
      syncModeSelect && !autobaudEnable |=> !autobaudEnable;
   endproperty
   a_syncRefuse: assert property (p_syncRefuse) else $error("autobaud in sync mode");
   property p_measureArmed;
      $rose(autobaudMeasure) |-> autobaudEnable;
   endproperty
   a_measureArmed: assert property (p_measureArmed) else $error("measure without enable");
   property p_endFlag;
      $fell(autobaudEnable) |-> receiveCompleteFlag && !autobaudMeasure;
   endproperty
   a_endFlag: assert property (p_endFlag) else $error("no flag at autobaud end");
   // Tx must stay quiet the whole measurement, the first cycle may still settle
   property p_txHeld;
      autobaudEnable && $past(autobaudEnable) |-> txOut && !txReady;
   endproperty
   a_txHeld: assert property (p_txHeld) else $error("tx active while measuring");
   property p_countUp;
      autobaudMeasure && $past(autobaudMeasure)
         |-> {rateDividerHigh, rateDividerLow} == $past({rateDividerHigh, rateDividerLow})
          || {rateDividerHigh, rateDividerLow}
             == $past({rateDividerHigh, rateDividerLow}) + 16'h0001;
   endproperty
   a_countUp: assert property (p_countUp) else $error("divider not counting up");
   property p_countRate;
      autobaudMeasure && $changed({rateDividerHigh, rateDividerLow})
         |=> $stable({rateDividerHigh, rateDividerLow}) [*8];
   endproperty
   a_countRate: assert property (p_countRate) else $error("divider counts too fast");
   property p_hold;
      !autobaudEnable && !autobaudSet && !dividerWrite
         |=> $stable({rateDividerHigh, rateDividerLow});
   endproperty
   a_hold: assert property (p_hold) else $error("divider result not held");
   property p_txStart;
      txValid && txReady |=> !txOut;
   endproperty
   a_txStart: assert property (p_txStart) else $error("no start bit after load");
   property p_divWrite;
      dividerWrite && !autobaudEnable && !autobaudSet
         |=> {rateDividerHigh, rateDividerLow} == $past(dividerWriteValue);
   endproperty
   a_divWrite: assert property (p_divWrite) else $error("divider write lost");
endmodule

bind async_uart_autobaud async_uart_autobaud_sva async_uart_autobaud_sva_i (
   .clk(clk), .rst_n(rst_n), .syncModeSelect(syncModeSelect), .autobaudSet(autobaudSet),
   .dividerWrite(dividerWrite), .dividerWriteValue(dividerWriteValue), .txValid(txValid),
   .txReady(txReady), .txOut(txOut), .autobaudEnable(autobaudEnable),
   .autobaudMeasure(autobaudMeasure), .rateDividerLow(rateDividerLow),
   .rateDividerHigh(rateDividerHigh), .receiveCompleteFlag(receiveCompleteFlag));

// ===== tb/remote_node.sv
// Remote asynchronous serial node facing the block's serial pins
module remote_node (
   input  wire  clk,
   input  wire  txLine,
   output logic rxLine
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rxLine = 1'b1;
   // Start low, data LSB first, stop high; caller enters just after a rising edge
   task automatic send_word(input logic [8:0] w, input int nbits, input int period);
      rxLine <= 1'b0;
      repeat (period) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         rxLine <= w[i];
         repeat (period) @(posedge clk);
      end
      rxLine <= 1'b1;
      repeat (period) @(posedge clk);
   endtask
   task automatic send_break(input int lowCycles);
      rxLine <= 1'b0;
      repeat (lowCycles) @(posedge clk);
      rxLine <= 1'b1;
   endtask
   // Samples mid-bit on falling edges so the registered line has settled
   task automatic get_word(output logic [9:0] w, input int nbits, input int period);
      int n;
      w = '1;
      n = 0;
      while (txLine !== 1'b0 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      repeat (period / 2) @(negedge clk);
      for (int i = 0; i <= nbits; i++) begin
         repeat (period) @(negedge clk);
         w[i] = txLine;
      end
   endtask
endmodule

// ===== tb/test_async_uart_autobaud.sv
// Self-checking bench for the autobaud serial block
module test_async_uart_autobaud;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, syncModeSelect, wakeOnBreakEnable, highSpeedSelect;
   logic        wideDividerSelect, autobaudSet, dividerWrite, nineBitMode, txValid;
   logic        rxReady, receiveBufferRead, txReady, txOut, rxValid, autobaudEnable;
   logic        autobaudMeasure, receiveCompleteFlag, breakSeen, rxIn;
   logic [15:0] dividerWriteValue;
   logic [8:0]  txData, rxData, r;
   logic [7:0]  rateDividerLow, rateDividerHigh;
   logic [3:0]  wTab, hTab;
   int          error_cnt, tests_run, cycles;
   async_uart_autobaud async_uart_autobaud_i (
      .clk(clk), .rst_n(rst_n), .syncModeSelect(syncModeSelect),
      .wakeOnBreakEnable(wakeOnBreakEnable), .highSpeedSelect(highSpeedSelect),
      .wideDividerSelect(wideDividerSelect), .autobaudSet(autobaudSet),
      .dividerWrite(dividerWrite), .dividerWriteValue(dividerWriteValue),
      .nineBitMode(nineBitMode), .txValid(txValid), .txData(txData), .txReady(txReady),
      .rxIn(rxIn), .txOut(txOut), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
      .autobaudEnable(autobaudEnable), .autobaudMeasure(autobaudMeasure),
      .rateDividerLow(rateDividerLow), .rateDividerHigh(rateDividerHigh),
      .receiveCompleteFlag(receiveCompleteFlag), .receiveBufferRead(receiveBufferRead),
      .breakSeen(breakSeen));
   remote_node remote_node_i (.clk(clk), .txLine(txOut), .rxLine(rxIn));
   // ----------------------------------------
   // Clock, timeout and report
   // ----------------------------------------
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------
   // Access tasks, entered just after a rising edge
   // ----------------------------------------
   task automatic put_tx(input logic [8:0] w);
      int n;
      n = 0;
      txValid <= 1'b1;
      txData  <= w;
      @(negedge clk);
      while (txReady !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      txValid <= 1'b0;
   endtask
   task automatic get_rx(output logic [8:0] w);
      int n;
      n = 0;
      rxReady <= 1'b1;
      @(negedge clk);
      while (rxValid !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      w = rxData;
      @(posedge clk);
      rxReady <= 1'b0;
   endtask
   task automatic run_data(input logic w, h, nine, input logic [15:0] div,
                           input logic [8:0] tw, rw);
      logic [9:0] got;
      logic [8:0] rr;
      wideDividerSelect <= w;
      highSpeedSelect   <= h;
      nineBitMode       <= nine;
      dividerWrite      <= 1'b1;
      dividerWriteValue <= div;
      @(posedge clk);
      dividerWrite <= 1'b0;
      @(posedge clk);
      // Both directions at once, 64 clocks a bit in every mode
      fork
         put_tx(tw);
         remote_node_i.get_word(got, nine ? 9 : 8, 64);
         remote_node_i.send_word(rw, nine ? 9 : 8, 64);
         get_rx(rr);
      join
      check("txWord", got, nine ? {1'b1, tw} : {2'b11, tw[7:0]});
      check("rxWord", rr & (nine ? 9'h1FF : 9'h0FF), rw);
   endtask
   // Count expected is bit period over prescale, one step of slack for edge phase
   task automatic run_ab(input logic w, h, wk, input int period, input int expc);
      int n;
      logic [15:0] cnt;
      n = 0;
      wideDividerSelect <= w;
      highSpeedSelect   <= h;
      wakeOnBreakEnable <= wk;
      autobaudSet       <= 1'b1;
      receiveBufferRead <= 1'b1;
      @(posedge clk);
      autobaudSet       <= 1'b0;
      receiveBufferRead <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("abEnable", autobaudEnable, 16'h0001);
      check("abFlagIdle", receiveCompleteFlag, 16'h0000);
      check("abCleared", {rateDividerHigh, rateDividerLow}, 16'h0000);
      check("abTxHeld", {txReady, txOut}, 16'h0001);
      @(posedge clk);
      if (wk) remote_node_i.send_break(3000);
      repeat (period) @(posedge clk);
      remote_node_i.send_word(9'h055, 8, period);
      while (autobaudEnable !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      cnt = {rateDividerHigh, rateDividerLow};
      check("abHigh", rateDividerHigh, 16'h0000);
      check("abCount", cnt + 16'h0001 >= expc && cnt <= expc + 1, 16'h0001);
      check("abDone", {autobaudEnable, receiveCompleteFlag}, 16'h0001);
      check("abBreak", breakSeen, {15'h0000, wk});
      @(posedge clk);
      receiveBufferRead <= 1'b1;
      @(posedge clk);
      receiveBufferRead <= 1'b0;
      @(negedge clk);
      check("abFlagClr", receiveCompleteFlag, 16'h0000);
      @(posedge clk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, syncModeSelect, wakeOnBreakEnable, highSpeedSelect, wideDividerSelect} = '0;
      {autobaudSet, dividerWrite, nineBitMode, txValid, rxReady, receiveBufferRead} = '0;
      dividerWriteValue = 16'h0000;
      txData = 9'h000;
      {error_cnt, tests_run, cycles} = '0;
      wTab = 4'b0101;
      hTab = 4'b1001;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("rstFlags", {txOut, rxValid, autobaudEnable, receiveCompleteFlag, breakSeen},
            16'h0010);
      check("rstDivider", {rateDividerHigh, rateDividerLow}, 16'h0000);
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         run_data(wTab[i], hTab[i], i[0], (wTab[i] & hTab[i]) ? 16'h000F
                  : (wTab[i] | hTab[i]) ? 16'h0003 : 16'h0000,
                  9'h0A5 ^ i, (9'h13C + i) & (i[0] ? 9'h1FF : 9'h0FF));
      end
      // Three words into a two-entry buffer with the reader stalled: last is dropped
      for (int i = 0; i < 3; i++) remote_node_i.send_word(9'h1A0 + i, 9, 64);
      for (int i = 0; i < 2; i++) begin
         get_rx(r);
         check("bufWord", r, 9'h1A0 + i);
         @(posedge clk);
      end
      @(negedge clk);
      check("bufEmpty", rxValid, 16'h0000);
      @(posedge clk);
      syncModeSelect <= 1'b1;
      @(posedge clk);
      autobaudSet <= 1'b1;
      @(posedge clk);
      autobaudSet <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("syncRefuse", autobaudEnable, 16'h0000);
      @(posedge clk);
      syncModeSelect <= 1'b0;
      @(posedge clk);
      run_ab(1'b1, 1'b1, 1'b0, 1280, 40);
      run_ab(1'b1, 1'b0, 1'b0, 1280, 10);
      run_ab(1'b0, 1'b0, 1'b0, 2560, 5);
      run_ab(1'b1, 1'b1, 1'b1, 1280, 40);
      stop_test();
   end
endmodule
